// ===== coe_output_logic.sv
// Custom digital output: status events, trajectory status and position triggers
`timescale 1ns/1ns
`default_nettype none

`include "coe_params.svh"

module coe_output_logic #(
	parameter int FAULT_W = 16,
	parameter int WARN_W  = 11,
	parameter int POS_W   = 32,
	parameter int CNT_W   = 32
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    srst,
	// Amplifier state
	input  wire logic                    enableInputsOk,
	input  wire logic                    swDisabled,
	input  wire logic                    velPosMode,
	input  wire logic                    brakeActive,
	input  wire logic                    pwmStageOff,
	input  wire logic                    homeSwitch,
	input  wire logic [FAULT_W-1:0]      faults,
	input  wire logic [WARN_W-1:0]       warnings,
	// Trajectory state
	input  wire logic                    moveStart,
	input  wire logic                    genRunning,
	input  wire logic                    inTrackWindow,
	input  wire logic [CNT_W-1:0]        trackTicks,
	input  wire logic                    homeStart,
	input  wire logic                    homeDoneOk,
	input  wire logic                    homeDoneErr,
	input  wire logic                    moveAbort,
	input  wire logic                    camBufErr,
	// Position samples
	input  wire logic                    servoTick,
	input  wire logic signed [POS_W-1:0] actualPos,
	// Output configuration
	input  wire coe_pkg::coe_func_e      outFunc,
	input  wire logic                    activeLow,
	input  wire logic                    latchEn,
	input  wire logic [FAULT_W-1:0]      faultSel,
	input  wire logic [WARN_W-1:0]       warnSel,
	input  wire logic [`COE_ST_WIDTH-1:0] statusSel,
	input  wire logic [`COE_TJ_WIDTH-1:0] trajSel,
	input  wire coe_pkg::coe_posmode_e   posMode,
	input  wire logic signed [POS_W-1:0] lowerPos,
	input  wire logic signed [POS_W-1:0] upperPos,
	input  wire logic signed [POS_W-1:0] trigPos,
	input  wire logic [CNT_W-1:0]        pulseTicks,
	// Clearing
	input  wire logic                    clearReq,
	input  wire logic                    enableClears,
	// Results
	output logic                         outPin_r,
	output logic [`COE_ST_WIDTH-1:0]     statusEv_r,
	output logic [`COE_TJ_WIDTH-1:0]     trajCond_r,
	output logic                         outLatched_r
);
	import coe_pkg::*;

	// Any selected bit set; inputs widened so one function serves all vectors
	function automatic logic coeAnySel(input logic [`COE_WIDE_WIDTH-1:0] vec, sel);
		return |(vec & sel);
	endfunction

	logic                    enabled;
	logic                    enabledPrev_r;
	logic                    stopping_r;
	logic                    reEnable;
	logic                    latchClear;
	coe_settle_e             settle_r;
	coe_settle_e             settle_nxt;
	logic [CNT_W-1:0]        settleCnt_r;
	logic                    homing_r;
	logic                    homeErr_r;
	logic                    referenced_r;
	logic                    aborted_r;
	logic                    camErr_r;
	logic                    posActive_r;
	logic [`COE_ST_WIDTH-1:0] statusNow;
	logic [`COE_TJ_WIDTH-1:0] trajNow;
	logic                    eventHit;
	logic                    trajHit;
	logic                    active;

	// Amplifier counts as enabled only with hardware and software both allowing it
	assign enabled  = enableInputsOk && !swDisabled;
	assign reEnable = enableInputsOk && !enabledPrev_r;
	// Remember the hardware enable state to see re-enable edges
	always_ff @(posedge mclk) begin
		if (srst) begin
			enabledPrev_r <= 1'b0;
		end else begin
			enabledPrev_r <= enableInputsOk;
		end
	end

	// Stopping covers the decel ramp and stays until the drive is enabled again
	always_ff @(posedge mclk) begin
		if (srst) begin
			stopping_r <= 1'b0;
		end else if (enabled) begin
			stopping_r <= 1'b0;
		end else if (velPosMode && !stopping_r) begin
			stopping_r <= 1'b1;
		end
	end

	// Settle tracker: timer restarts whenever the position leaves the window before settling
	always_comb begin
		settle_nxt = settle_r;
		unique case (settle_r)
			COE_SS_MOVING_C: begin
				if (!moveStart && !genRunning && inTrackWindow) begin
					settle_nxt = COE_SS_WAITING_C;
				end
			end
			COE_SS_WAITING_C: begin
				if (moveStart || genRunning || !inTrackWindow) begin
					settle_nxt = COE_SS_MOVING_C;
				end else if (settleCnt_r >= trackTicks) begin
					settle_nxt = COE_SS_SETTLED_C;
				end
			end
			COE_SS_SETTLED_C: begin
				if (moveStart) begin
					settle_nxt = COE_SS_MOVING_C;
				end
			end
			default: settle_nxt = COE_SS_MOVING_C;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			settle_r <= COE_SS_SETTLED_C;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	// Time spent inside the tracking window, in clock ticks
	always_ff @(posedge mclk) begin
		if (srst) begin
			settleCnt_r <= '0;
		end else if (settle_r == COE_SS_WAITING_C && settleCnt_r != '1) begin
			settleCnt_r <= settleCnt_r + 1'b1;
		end else if (settle_r != COE_SS_WAITING_C) begin
			settleCnt_r <= CNT_W'(1);
		end
	end

	// Homing progress; a new attempt wipes the previous outcome
	always_ff @(posedge mclk) begin
		if (srst) begin
			homing_r     <= 1'b0;
			homeErr_r    <= 1'b0;
			referenced_r <= 1'b0;
		end else if (homeStart) begin
			homing_r     <= 1'b1;
			homeErr_r    <= 1'b0;
			referenced_r <= 1'b0;
		end else if (homeDoneErr) begin
			homing_r     <= 1'b0;
			homeErr_r    <= 1'b1;
			referenced_r <= 1'b0;
		end else if (homeDoneOk) begin
			homing_r     <= 1'b0;
			homeErr_r    <= 1'b0;
			referenced_r <= 1'b1;
		end
	end

	// Abort flag lives until the next move; set wins over the clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			aborted_r <= 1'b0;
		end else if (moveAbort) begin
			aborted_r <= 1'b1;
		end else if (moveStart) begin
			aborted_r <= 1'b0;
		end
	end

	// Cam buffer error sticks until faults are cleared; set wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			camErr_r <= 1'b0;
		end else if (camBufErr) begin
			camErr_r <= 1'b1;
		end else if (clearReq) begin
			camErr_r <= 1'b0;
		end
	end

	// Live status event and trajectory condition vectors
	always_comb begin
		statusNow[`COE_ST_HWDIS]      = !enableInputsOk;
		statusNow[`COE_ST_SWDIS]      = swDisabled;
		statusNow[`COE_ST_STOPPING]   = stopping_r;
		statusNow[`COE_ST_BRAKE]      = brakeActive;
		statusNow[`COE_ST_PWMOFF]     = pwmStageOff;
		statusNow[`COE_ST_HOMESW]     = homeSwitch;
		statusNow[`COE_ST_NOTSETTLED] = settle_r != COE_SS_SETTLED_C;
		trajNow[`COE_TJ_HOMEERR]      = homeErr_r;
		trajNow[`COE_TJ_REFERENCED]   = referenced_r;
		trajNow[`COE_TJ_HOMING]       = homing_r;
		trajNow[`COE_TJ_ABORTED]      = aborted_r;
		trajNow[`COE_TJ_GENRUN]       = genRunning;
		trajNow[`COE_TJ_CAMERR]       = camErr_r;
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			statusEv_r <= '0;
			trajCond_r <= '0;
		end else begin
			statusEv_r <= statusNow;
			trajCond_r <= trajNow;
		end
	end

	// Faults are observed live here and held only by the event latch, so with latchEn off a drive fault clears on its own
	assign eventHit = coeAnySel(`COE_WIDE_WIDTH'(faults), `COE_WIDE_WIDTH'(faultSel))
		|| coeAnySel(`COE_WIDE_WIDTH'(warnings), `COE_WIDE_WIDTH'(warnSel))
		|| coeAnySel(`COE_WIDE_WIDTH'(statusNow), `COE_WIDE_WIDTH'(statusSel));
	assign trajHit = coeAnySel(`COE_WIDE_WIDTH'(trajNow), `COE_WIDE_WIDTH'(trajSel));
	// Clear by request or by re-enabling when enables are set to clear
	assign latchClear = clearReq || (enableClears && reEnable);
	// Latch for custom events; a live event beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			outLatched_r <= 1'b0;
		end else if (outFunc == COE_FN_EVENT_C && latchEn && eventHit) begin
			outLatched_r <= 1'b1;
		end else if (latchClear || !latchEn || outFunc != COE_FN_EVENT_C) begin
			outLatched_r <= 1'b0;
		end
	end

	coe_pos_trigger #(
		.POS_W (POS_W),
		.CNT_W (CNT_W)
	) uPosTrig (
		.mclk        (mclk),
		.srst        (srst),
		.posMode     (posMode),
		.lowerPos    (lowerPos),
		.upperPos    (upperPos),
		.trigPos     (trigPos),
		.pulseTicks  (pulseTicks),
		.servoTick   (servoTick),
		.actualPos   (actualPos),
		.posActive_r (posActive_r)
	);

	// Active level of the chosen function; host sets one trigger mode
	always_comb begin
		unique case (outFunc)
			COE_FN_EVENT_C:   active = eventHit || outLatched_r;
			COE_FN_TRAJ_C:    active = trajHit;
			COE_FN_POSTRIG_C: active = posActive_r;
			COE_FN_NONE_C:    active = 1'b0;
		endcase
	end

	// Pin stays high when unconfigured, otherwise polarity applies
	always_ff @(posedge mclk) begin
		if (srst) begin
			outPin_r <= `COE_PIN_IDLE;
		end else if (outFunc == COE_FN_NONE_C) begin
			outPin_r <= `COE_PIN_IDLE;
		end else begin
			outPin_r <= active ^ activeLow;
		end
	end

	// Checks; settling is a two-step behaviour, so it gets a named sequence
	sequence settleEntrySeq;
		settle_r != COE_SS_SETTLED_C ##1 settle_r == COE_SS_SETTLED_C;
	endsequence

	hw_disable_a: assert property (@(posedge mclk) disable iff (srst)
		!enableInputsOk |=> statusEv_r[`COE_ST_HWDIS])
		else $error("hardware disable event missing");
	sw_disable_a: assert property (@(posedge mclk) disable iff (srst)
		swDisabled |=> statusEv_r[`COE_ST_SWDIS])
		else $error("software disable event missing");
	stop_event_a: assert property (@(posedge mclk) disable iff (srst)
		!enabled && (velPosMode || stopping_r) |=> stopping_r)
		else $error("stopping event dropped before re-enable");
	stop_clear_a: assert property (@(posedge mclk) disable iff (srst)
		enabled |=> !stopping_r)
		else $error("stopping event held while enabled");
	brake_pwm_a: assert property (@(posedge mclk) disable iff (srst)
		1'b1 |=> statusEv_r[`COE_ST_BRAKE] == $past(brakeActive)
			&& statusEv_r[`COE_ST_PWMOFF] == $past(pwmStageOff)
			&& statusEv_r[`COE_ST_HOMESW] == $past(homeSwitch))
		else $error("brake, stage or home event mismatch");
	settle_hold_a: assert property (@(posedge mclk) disable iff (srst)
		settle_r == COE_SS_SETTLED_C && !moveStart |=> settle_r == COE_SS_SETTLED_C)
		else $error("settled dropped without a new move");
	settle_entry_a: assert property (@(posedge mclk) disable iff (srst)
		settleEntrySeq |-> $past(inTrackWindow) && $past(settleCnt_r) >= $past(trackTicks))
		else $error("settled without dwell in window");
	home_result_a: assert property (@(posedge mclk) disable iff (srst)
		homeDoneErr && !homeStart |=> homeErr_r && !referenced_r && !homing_r)
		else $error("homing error not reported");
	home_ok_a: assert property (@(posedge mclk) disable iff (srst)
		homeDoneOk && !homeStart && !homeDoneErr |=> referenced_r && !homeErr_r)
		else $error("referenced not reported");
	home_busy_a: assert property (@(posedge mclk) disable iff (srst)
		homeStart |=> homing_r)
		else $error("homing in progress missing");
	abort_flag_a: assert property (@(posedge mclk) disable iff (srst)
		moveAbort |=> aborted_r)
		else $error("move aborted not flagged");
	cam_flag_a: assert property (@(posedge mclk) disable iff (srst)
		camBufErr |=> camErr_r[*2] or (camErr_r ##1 !camErr_r))
		else $error("cam buffer error not flagged");
	traj_or_a: assert property (@(posedge mclk) disable iff (srst)
		outFunc == COE_FN_TRAJ_C && $stable(outFunc) && trajHit |=> outPin_r == !$past(activeLow))
		else $error("trajectory output not active");
	event_or_a: assert property (@(posedge mclk) disable iff (srst)
		outFunc == COE_FN_EVENT_C && eventHit |=> outPin_r == !$past(activeLow))
		else $error("event output not active");
	event_drop_a: assert property (@(posedge mclk) disable iff (srst)
		outFunc == COE_FN_EVENT_C && !latchEn && !eventHit |=> outPin_r == $past(activeLow))
		else $error("unlatched output held");
	latch_hold_a: assert property (@(posedge mclk) disable iff (srst)
		outLatched_r && !latchClear && latchEn && outFunc == COE_FN_EVENT_C |=> outLatched_r)
		else $error("latched output released early");
	idle_pin_a: assert property (@(posedge mclk) disable iff (srst)
		outFunc == COE_FN_NONE_C |=> outPin_r)
		else $error("unconfigured output not high");

endmodule : coe_output_logic // coe_output_logic

`default_nettype wire

// ===== coe_params.svh
// Constants for the custom output event logic: bit positions, codes, reset values
`ifndef COE_PARAMS_SVH
`define COE_PARAMS_SVH

// Status event vector bit positions
`define COE_ST_HWDIS      0
`define COE_ST_SWDIS      1
`define COE_ST_STOPPING   2
`define COE_ST_BRAKE      3
`define COE_ST_PWMOFF     4
`define COE_ST_HOMESW     5
`define COE_ST_NOTSETTLED 6
`define COE_ST_WIDTH      7

// Trajectory condition vector bit positions
`define COE_TJ_HOMEERR    0
`define COE_TJ_REFERENCED 1
`define COE_TJ_HOMING     2
`define COE_TJ_ABORTED    3
`define COE_TJ_GENRUN     4
`define COE_TJ_CAMERR     5
`define COE_TJ_WIDTH      6

// Output function codes
`define COE_FN_NONE       2'h0
`define COE_FN_EVENT      2'h1
`define COE_FN_TRAJ       2'h2
`define COE_FN_POSTRIG    2'h3

// Position trigger configuration codes
`define COE_PM_WINDOW     2'h0
`define COE_PM_ANYDIR     2'h1
`define COE_PM_POSDIR     2'h2
`define COE_PM_NEGDIR     2'h3

// Settle tracker state codes
`define COE_SS_MOVING     2'h0
`define COE_SS_WAITING    2'h1
`define COE_SS_SETTLED    2'h2

// Reset value and widening width
`define COE_PIN_IDLE      1'h1
`define COE_WIDE_WIDTH    32

`endif

// ===== coe_pin_sense.sv
// Model of the outside equipment that senses the output pin
`timescale 1ns/1ns
`default_nettype none

module coe_pin_sense (
	// Sensed pin and the polarity it was set up for
	input  wire logic pinLevel,
	input  wire logic activeLow,
	// What the equipment concludes
	output logic      sensedActive
);
	// Equipment knows the polarity, so it reads active regardless of level choice
	assign sensedActive = pinLevel ^ activeLow;
endmodule // coe_pin_sense

`default_nettype wire

// ===== coe_pkg.sv
// Types shared by the custom output event logic
`include "coe_params.svh"

package coe_pkg;

	// Function chosen for the output pin
	typedef enum logic [1:0] {
		COE_FN_NONE_C    = `COE_FN_NONE,
		COE_FN_EVENT_C   = `COE_FN_EVENT,
		COE_FN_TRAJ_C    = `COE_FN_TRAJ,
		COE_FN_POSTRIG_C = `COE_FN_POSTRIG
	} coe_func_e;

	// Position trigger configuration
	typedef enum logic [1:0] {
		COE_PM_WINDOW_C = `COE_PM_WINDOW,
		COE_PM_ANYDIR_C = `COE_PM_ANYDIR,
		COE_PM_POSDIR_C = `COE_PM_POSDIR,
		COE_PM_NEGDIR_C = `COE_PM_NEGDIR
	} coe_posmode_e;

	// Settle tracker states
	typedef enum logic [1:0] {
		COE_SS_MOVING_C  = `COE_SS_MOVING,
		COE_SS_WAITING_C = `COE_SS_WAITING,
		COE_SS_SETTLED_C = `COE_SS_SETTLED
	} coe_settle_e;

endpackage : coe_pkg

// ===== coe_pos_trigger.sv
// Position triggered activity: window compare and timed crossing pulse
`timescale 1ns/1ns
`default_nettype none

module coe_pos_trigger #(
	parameter int POS_W = 32,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    srst,
	// Configuration
	input  wire coe_pkg::coe_posmode_e   posMode,
	input  wire logic signed [POS_W-1:0] lowerPos,
	input  wire logic signed [POS_W-1:0] upperPos,
	input  wire logic signed [POS_W-1:0] trigPos,
	input  wire logic        [CNT_W-1:0] pulseTicks,
	// Position samples
	input  wire logic                    servoTick,
	input  wire logic signed [POS_W-1:0] actualPos,
	// Result
	output logic                         posActive_r
);
	import coe_pkg::*;

	logic signed [POS_W-1:0] prevPos_r;
	logic                    prevValid_r;
	logic        [CNT_W-1:0] pulseCnt_r;
	logic                    upCross;
	logic                    dnCross;
	logic                    hit;

	// Crossing seen between the previous and current servo sample
	assign upCross = servoTick && prevValid_r && (prevPos_r < trigPos) && (actualPos >= trigPos);
	assign dnCross = servoTick && prevValid_r && (prevPos_r > trigPos) && (actualPos <= trigPos);
	always_comb begin
		unique case (posMode)
			COE_PM_ANYDIR_C: hit = upCross || dnCross;
			COE_PM_POSDIR_C: hit = upCross;
			COE_PM_NEGDIR_C: hit = dnCross;
			COE_PM_WINDOW_C: hit = 1'b0;
		endcase
	end

	// Previous sample; first sample after reset cannot make a crossing
	always_ff @(posedge mclk) begin
		if (srst) begin
			prevPos_r   <= '0;
			prevValid_r <= 1'b0;
		end else if (servoTick) begin
			prevPos_r   <= actualPos;
			prevValid_r <= 1'b1;
		end
	end

	// Pulse length in clock ticks; a fresh crossing restarts it
	always_ff @(posedge mclk) begin
		if (srst) begin
			pulseCnt_r <= '0;
		end else if (hit) begin
			pulseCnt_r <= pulseTicks;
		end else if (pulseCnt_r != '0) begin
			pulseCnt_r <= pulseCnt_r - 1'b1;
		end
	end

	// Window compares the live position, pulse modes use the counter
	always_ff @(posedge mclk) begin
		if (srst) begin
			posActive_r <= 1'b0;
		end else if (posMode == COE_PM_WINDOW_C) begin
			posActive_r <= (actualPos >= lowerPos) && (actualPos <= upperPos);
		end else begin
			posActive_r <= hit ? (pulseTicks != '0) : (pulseCnt_r > 1);
		end
	end

	restart_cnt_a: assert property (@(posedge mclk) disable iff (srst)
		hit |=> pulseCnt_r == $past(pulseTicks))
		else $error("pulse counter not reloaded on crossing");
	window_out_a: assert property (@(posedge mclk) disable iff (srst)
		(posMode == COE_PM_WINDOW_C) |=> posActive_r == (($past(actualPos) >= $past(lowerPos))
			&& ($past(actualPos) <= $past(upperPos))))
		else $error("window output mismatch");

endmodule : coe_pos_trigger // coe_pos_trigger

`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the custom output event logic
`timescale 1ns/1ns
`default_nettype none
`include "coe_params.svh"

module tb_top;
	import coe_pkg::*;
	// Stimulus, all driven 1 ns after the rising edge
	logic mclk = 1'b0, srst = 1'b1, enableInputsOk = 1'b1, swDisabled = 1'b0;
	logic velPosMode = 1'b0, brakeActive = 1'b0, pwmStageOff = 1'b0, homeSwitch = 1'b0;
	logic moveStart = 1'b0, genRunning = 1'b0, inTrackWindow = 1'b1, homeStart = 1'b0;
	logic homeDoneOk = 1'b0, homeDoneErr = 1'b0, moveAbort = 1'b0, camBufErr = 1'b0;
	logic servoTick = 1'b0, activeLow = 1'b0, latchEn = 1'b0, clearReq = 1'b0;
	logic enableClears = 1'b0;
	logic [15:0] faults = 16'h0, faultSel = 16'h0;
	logic [10:0] warnings = 11'h0, warnSel = 11'h0;
	logic [`COE_ST_WIDTH-1:0] statusSel = 7'h0;
	logic [`COE_TJ_WIDTH-1:0] trajSel = 6'h0;
	logic [31:0] trackTicks = 32'h4, pulseTicks = 32'h4;
	logic signed [31:0] actualPos = 32'h0, lowerPos = 32'hFFFFFFF6;
	logic signed [31:0] upperPos = 32'hA, trigPos = 32'h64;
	coe_func_e outFunc = COE_FN_NONE_C;
	coe_posmode_e posMode = COE_PM_WINDOW_C;
	// Observed
	logic outPin_r, outLatched_r, sensedActive;
	logic [`COE_ST_WIDTH-1:0] statusEv_r;
	logic [`COE_TJ_WIDTH-1:0] trajCond_r;
	int checks = 0;
	int error_cnt = 0;
	int n;

	coe_output_logic coe_output_logic_i (
		.mclk(mclk), .srst(srst), .enableInputsOk(enableInputsOk), .swDisabled(swDisabled),
		.velPosMode(velPosMode), .brakeActive(brakeActive), .pwmStageOff(pwmStageOff),
		.homeSwitch(homeSwitch), .faults(faults), .warnings(warnings), .moveStart(moveStart),
		.genRunning(genRunning), .inTrackWindow(inTrackWindow), .trackTicks(trackTicks),
		.homeStart(homeStart), .homeDoneOk(homeDoneOk), .homeDoneErr(homeDoneErr),
		.moveAbort(moveAbort), .camBufErr(camBufErr), .servoTick(servoTick),
		.actualPos(actualPos), .outFunc(outFunc), .activeLow(activeLow), .latchEn(latchEn),
		.faultSel(faultSel), .warnSel(warnSel), .statusSel(statusSel), .trajSel(trajSel),
		.posMode(posMode), .lowerPos(lowerPos), .upperPos(upperPos), .trigPos(trigPos),
		.pulseTicks(pulseTicks), .clearReq(clearReq), .enableClears(enableClears),
		.outPin_r(outPin_r), .statusEv_r(statusEv_r), .trajCond_r(trajCond_r),
		.outLatched_r(outLatched_r)
	);

	coe_pin_sense coe_pin_sense_i (
		.pinLevel(outPin_r), .activeLow(activeLow), .sensedActive(sensedActive)
	);

	// 250 MHz control clock
	always #2 mclk = ~mclk;

	// Wait k edges, then step clear of the edge so reads see settled values
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle strobe on a pulse input, then time for the flag to land
	task automatic hit(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(2);
	endtask

	// One-cycle pulse on the selected fault bit; a bit-select cannot pass by reference
	task automatic fault_pulse;
		faults[3] = 1'b1;
		tick(1);
		faults[3] = 1'b0;
		tick(2);
	endtask

	task automatic setpos(input logic [31:0] p);
		actualPos = p;
		servoTick = 1'b1;
		tick(1);
		servoTick = 1'b0;
	endtask

	// Counts active-high pin cycles; window covers a restarted pulse too
	task automatic count_active(output int c);
		c = 0;
		repeat (12) begin
			tick(1);
			if (outPin_r === 1'b1) c++;
		end
	endtask

	task automatic summarize;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		tick(12);
		srst = 1'b0;
		tick(1);
		chk(outPin_r, 1'b1);
		// Status events but not-settled, all raised then released in steps
		{swDisabled, velPosMode, brakeActive, pwmStageOff, homeSwitch} = 5'h1F;
		enableInputsOk = 1'b0;
		tick(2);
		chk(statusEv_r[5:0], 6'h3F);
		{velPosMode, brakeActive, pwmStageOff, homeSwitch} = 4'h0;
		enableInputsOk = 1'b1;
		tick(2);
		chk(statusEv_r[5:0], 6'h06);
		swDisabled = 1'b0;
		tick(2);
		chk(statusEv_r[5:0], 6'h00);
		enableInputsOk = 1'b0;
		tick(2);
		chk(statusEv_r[5:0], 6'h01);
		enableInputsOk = 1'b1;
		$display("test status done");
		// Settling: move, dwell in window, then excursion after settling
		genRunning = 1'b1;
		inTrackWindow = 1'b0;
		hit(moveStart);
		chk(statusEv_r[6], 1'b1);
		genRunning = 1'b0;
		tick(2);
		chk(statusEv_r[6], 1'b1);
		inTrackWindow = 1'b1;
		tick(2);
		chk(statusEv_r[6], 1'b1);
		n = 0;
		while (statusEv_r[6] !== 1'b0 && n < 20) begin
			tick(1);
			n++;
		end
		if (n == 20) begin
			error_cnt++;
			summarize();
		end
		inTrackWindow = 1'b0;
		tick(3);
		chk(statusEv_r[6], 1'b0);
		$display("test settle done");
		// Custom event output in both polarities
		outFunc = COE_FN_EVENT_C;
		faultSel = 16'h0008;
		warnSel = 11'h004;
		statusSel = 7'h08;
		for (int pol = 0; pol < 2; pol++) begin
			activeLow = pol[0];
			faults = 16'h0008;
			tick(3);
			chk(outPin_r, !pol[0]);
			faults = 16'h0000;
			warnings = 11'h004;
			tick(3);
			chk(sensedActive, 1'b1);
			warnings = 11'h000;
			brakeActive = 1'b1;
			tick(3);
			chk(sensedActive, 1'b1);
			brakeActive = 1'b0;
			faults = 16'h0004;
			tick(3);
			chk(outPin_r, pol[0]);
			faults = 16'h0000;
		end
		// Latched output: amplifier re-enables, pin holds until cleared
		latchEn = 1'b1;
		fault_pulse();
		tick(1);
		chk({sensedActive, outLatched_r}, 2'h3);
		enableInputsOk = 1'b0;
		tick(2);
		enableInputsOk = 1'b1;
		tick(3);
		chk({statusEv_r[0], sensedActive}, 2'h1);
		hit(clearReq);
		chk(sensedActive, 1'b0);
		fault_pulse();
		chk(outLatched_r, 1'b1);
		enableClears = 1'b1;
		enableInputsOk = 1'b0;
		tick(2);
		enableInputsOk = 1'b1;
		tick(3);
		chk(sensedActive, 1'b0);
		latchEn = 1'b0;
		enableClears = 1'b0;
		$display("test event done");
		// Trajectory conditions
		outFunc = COE_FN_TRAJ_C;
		activeLow = 1'b0;
		trajSel = 6'h20;
		hit(moveAbort);
		chk({trajCond_r, outPin_r}, 7'h10);
		trajSel = 6'h3F;
		tick(2);
		chk(outPin_r, 1'b1);
		hit(moveStart);
		chk({trajCond_r, outPin_r}, 7'h00);
		hit(homeStart);
		chk(trajCond_r, 6'h04);
		hit(homeDoneOk);
		chk(trajCond_r, 6'h02);
		hit(homeStart);
		chk(trajCond_r, 6'h04);
		hit(homeDoneErr);
		chk(trajCond_r, 6'h01);
		hit(camBufErr);
		chk(trajCond_r, 6'h21);
		hit(clearReq);
		chk(trajCond_r, 6'h01);
		genRunning = 1'b1;
		tick(2);
		chk(trajCond_r, 6'h11);
		genRunning = 1'b0;
		tick(2);
		chk(trajCond_r, 6'h01);
		$display("test trajectory done");
		// Position triggers: window, then each crossing mode both ways
		outFunc = COE_FN_POSTRIG_C;
		posMode = COE_PM_WINDOW_C;
		setpos(32'hFFFFFFEC);
		tick(2);
		chk(outPin_r, 1'b0);
		setpos(32'h0);
		tick(2);
		chk(outPin_r, 1'b1);
		setpos(32'h14);
		tick(2);
		chk(outPin_r, 1'b0);
		for (int m = 1; m < 4; m++) begin
			posMode = coe_posmode_e'(m);
			setpos(32'h5A);
			tick(12);
			setpos(32'h6E);
			count_active(n);
			chk(n, (m != 3) ? pulseTicks : 32'h0);
			setpos(32'h5A);
			count_active(n);
			chk(n, (m != 2) ? pulseTicks : 32'h0);
		end
		posMode = COE_PM_ANYDIR_C;
		// Second crossing lands inside the pulse; full length after it only if restarted
		setpos(32'h6E);
		tick(1);
		setpos(32'h5A);
		count_active(n);
		chk(n, pulseTicks);
		$display("test position done");
		summarize();
	end
endmodule // tb_top

`default_nettype wire
